/* hdl/cmpd_pkg.sv */
// Constants and types for the comparator digital control block.
// Assumes an 8-bit register port and analog front ends outside this logic.
// Notes on behaviour
// [RULE1] Enable bit set runs the comparator; cleared, it draws minimum current.
// [RULE2] Result readable in control register A and in the mirror register.
// [RULE3] Software routes result to a pin and clears that pin's direction bit.
// [RULE4] Internal result latched every cycle; pin output is not latched.
// [RULE5] Invert clear: result 1 when positive input higher; invert set: complement.
// [RULE6] Hysteresis bit adds separation voltage at inputs; clearing removes it.
// [RULE7] Result offered as a gate source for the gated timer.
// [RULE8] Sync bit latches result on gated timer source clock falling edge.
// [RULE9] Software should enable sync when the result gates the timer.
// [RULE10] Enabled rising or falling result edge sets the interrupt flag.
// [RULE11] Software sets enable, interrupt enables and edge enables to get interrupts.
// [RULE12] Flag cleared only by software; an edge during the clear keeps it set.
// [RULE13] Edges from toggling invert or enable raise interrupts even when disabled.
// [RULE14] Three-bit positive select picks pin, converter, fixed reference or ground.
// [RULE15] Enable at 0 disconnects every comparator input regardless of selects.
// [RULE16] One comparator on the small variant, two independent on the large.
// [RULE17] Three-bit negative select picks pin, fixed reference or analog ground.
// [RULE18] Interrupt wakes from sleep; synced results freeze in sleep on core clock.
// [RULE19] Result bit read-only, resets to 0, reads 1 inverted when positive lower.
// [RULE20] Edges compare the adjusted result with the previous cycle's value.
package cmpd_pkg;
  localparam int          CMPD_MAX      = 2;
  localparam int          CMPD_AW       = 4;
  localparam int          CMPD_DW       = 8;
  // Register offsets
  localparam logic [3:0]  OFS_CTRL_A0   = 4'h0;
  localparam logic [3:0]  OFS_CTRL_B0   = 4'h1;
  localparam logic [3:0]  OFS_CTRL_A1   = 4'h2;
  localparam logic [3:0]  OFS_CTRL_B1   = 4'h3;
  localparam logic [3:0]  OFS_MIRROR    = 4'h4;
  localparam logic [3:0]  OFS_IRQ_FLAG  = 4'h5;
  localparam logic [3:0]  OFS_IRQ_EN    = 4'h6;
  // Control register A fields
  localparam int          BIT_ENABLE    = 7;
  localparam int          BIT_RESULT    = 6;
  localparam int          BIT_INVERT    = 4;
  localparam int          BIT_SPEED     = 2;
  localparam int          BIT_HYST      = 1;
  localparam int          BIT_SYNC      = 0;
  // Control register B fields
  localparam int          BIT_RISE_IE   = 7;
  localparam int          BIT_FALL_IE   = 6;
  localparam int          POS_SEL_LSB   = 3;
  localparam int          NEG_SEL_LSB   = 0;
  // Reset values
  localparam logic [7:0]  RST_CTRL_A    = 8'h04;
  localparam logic [7:0]  RST_CTRL_B    = 8'h00;
  localparam logic [7:0]  RST_IRQ       = 8'h00;
  // Input select codes
  localparam logic [2:0]  POS_PIN       = 3'h0;
  localparam logic [2:0]  POS_DAC       = 3'h1;
  localparam logic [2:0]  POS_FIXREF    = 3'h2;
  localparam logic [2:0]  POS_GROUND    = 3'h3;
  localparam logic [2:0]  NEG_PIN       = 3'h0;
  localparam logic [2:0]  NEG_FIXREF    = 3'h1;
  localparam logic [2:0]  NEG_GROUND    = 3'h2;

  typedef struct packed {
    logic       inputs_on;
    logic       enable;
    logic       hysteresis;
    logic       speed_power;
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
  } cmpd_analog_t;

  typedef struct packed {
    logic [CMPD_AW-1:0] addr;
    logic [CMPD_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } cmpd_bus_t;
endpackage

/* hdl/cmpd_top.sv */
// Digital control, result capture and edge flagging for one or two comparators.
// Assumes analog comparator outputs and the timer source clock arrive unsynchronised.
`timescale 1ns/1ns
`default_nettype none
module cmpd_top
  import cmpd_pkg::*;
#(
  parameter int NUM_CMP = 2
)(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire cmpd_bus_t            bus,
  output logic [CMPD_DW-1:0]        rdata,
  input  wire logic [NUM_CMP-1:0]   analog_raw,
  input  wire logic                 timer_src_clk,
  input  wire logic                 timer_src_core,
  input  wire logic                 sleep_mode,
  output cmpd_analog_t [NUM_CMP-1:0] analog_ctrl,
  output logic [NUM_CMP-1:0]        gate_source,
  output logic [NUM_CMP-1:0]        pin_result,
  output logic                      irq_request,
  output logic                      wake_request
);

  function automatic logic [CMPD_DW-1:0] ctrl_a_of(input logic [3:0] a);
    ctrl_a_of = 8'h00;
    if (a == OFS_CTRL_A0)
      ctrl_a_of = 8'h01;
    else if (a == OFS_CTRL_A1)
      ctrl_a_of = 8'h02;
  endfunction

  function automatic logic [CMPD_DW-1:0] ctrl_b_of(input logic [3:0] a);
    ctrl_b_of = 8'h00;
    if (a == OFS_CTRL_B0)
      ctrl_b_of = 8'h01;
    else if (a == OFS_CTRL_B1)
      ctrl_b_of = 8'h02;
  endfunction

  logic [7:0]         ctrl_a_reg [NUM_CMP];
  logic [7:0]         ctrl_b_reg [NUM_CMP];
  logic [NUM_CMP-1:0] flag_reg;
  logic [NUM_CMP-1:0] irq_en_reg;
  logic [NUM_CMP-1:0] raw_meta_reg;
  logic [NUM_CMP-1:0] raw_sync_reg;
  logic [NUM_CMP-1:0] sync_hold_reg;
  logic [NUM_CMP-1:0] result_reg;
  logic [NUM_CMP-1:0] prev_reg;
  logic [NUM_CMP-1:0] adjusted;
  logic [NUM_CMP-1:0] selected;
  logic [NUM_CMP-1:0] rise_evt;
  logic [NUM_CMP-1:0] fall_evt;
  logic [NUM_CMP-1:0] result_next;
  logic [2:0]         tclk_reg;
  logic               tclk_fall;
  logic               freeze;
  logic [7:0]         rdata_next;

  // Timer clock sampled, not used as a clock: one domain keeps the crossing simple
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tclk_reg <= 3'h0;
    else
      tclk_reg <= {tclk_reg[1:0], timer_src_clk};
  end

  assign tclk_fall = tclk_reg[2] & ~tclk_reg[1];
  // Core-clocked timer stops in sleep, so synced results stand still
  assign freeze    = sleep_mode & timer_src_core; // [RULE18]

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      raw_meta_reg <= '0;
      raw_sync_reg <= '0;
    end
    else
    begin
      raw_meta_reg <= analog_raw;
      raw_sync_reg <= raw_meta_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_CMP; i++)
    begin : g_cmp // [RULE16]
      logic               wr_a;
      logic               wr_b;
      logic [CMPD_DW-1:0] hit_a;
      logic [CMPD_DW-1:0] hit_b;
      // A function result cannot be indexed directly, so decode into a net first
      assign hit_a = ctrl_a_of(bus.addr);
      assign hit_b = ctrl_b_of(bus.addr);
      assign wr_a  = bus.wr & hit_a[i];
      assign wr_b  = bus.wr & hit_b[i];

      // Result bit is not writable
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          ctrl_a_reg[i] <= RST_CTRL_A;
        else if (wr_a)
          ctrl_a_reg[i] <= bus.wdata & 8'h97; // [RULE19]
      end

      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          ctrl_b_reg[i] <= RST_CTRL_B;
        else if (wr_b)
          ctrl_b_reg[i] <= bus.wdata;
      end

      // Disabled comparator reads low before inversion, so on/off makes an edge when the comparator output is high
      assign adjusted[i] = (raw_sync_reg[i] & ctrl_a_reg[i][BIT_ENABLE])
                           ^ ctrl_a_reg[i][BIT_INVERT]; // [RULE5] [RULE13]

      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          sync_hold_reg[i] <= 1'b0;
        else if (tclk_fall & ~freeze)
          sync_hold_reg[i] <= adjusted[i]; // [RULE8] [RULE18]
      end

      assign selected[i] = ctrl_a_reg[i][BIT_SYNC] ? sync_hold_reg[i] : adjusted[i];

      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          result_reg[i] <= 1'b0; // [RULE19]
        else
          result_reg[i] <= selected[i]; // [RULE4]
      end

      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          prev_reg[i] <= 1'b0;
        else
          prev_reg[i] <= result_reg[i]; // [RULE20]
      end

      assign rise_evt[i] = result_reg[i] & ~prev_reg[i]
                           & ctrl_b_reg[i][BIT_RISE_IE]; // [RULE10]
      assign fall_evt[i] = ~result_reg[i] & prev_reg[i]
                           & ctrl_b_reg[i][BIT_FALL_IE]; // [RULE10]

      // Set wins over a simultaneous software clear
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          flag_reg[i] <= 1'b0;
        else if (rise_evt[i] | fall_evt[i])
          flag_reg[i] <= 1'b1; // [RULE10] [RULE12]
        else if (bus.wr && bus.addr == OFS_IRQ_FLAG && !bus.wdata[i])
          flag_reg[i] <= 1'b0; // [RULE12]
      end

      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          irq_en_reg[i] <= 1'b0;
        else if (bus.wr && bus.addr == OFS_IRQ_EN)
          irq_en_reg[i] <= bus.wdata[i];
      end

      // Inputs disconnected whenever the comparator is off
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          analog_ctrl[i] <= '0;
        else
        begin
          analog_ctrl[i].enable      <= ctrl_a_reg[i][BIT_ENABLE]; // [RULE1]
          analog_ctrl[i].inputs_on   <= ctrl_a_reg[i][BIT_ENABLE]; // [RULE15]
          analog_ctrl[i].hysteresis  <= ctrl_a_reg[i][BIT_HYST]; // [RULE6]
          analog_ctrl[i].speed_power <= ctrl_a_reg[i][BIT_SPEED];
          analog_ctrl[i].pos_sel     <= ctrl_a_reg[i][BIT_ENABLE]
            ? ctrl_b_reg[i][POS_SEL_LSB +: 3] : POS_GROUND; // [RULE14] [RULE15]
          analog_ctrl[i].neg_sel     <= ctrl_a_reg[i][BIT_ENABLE]
            ? ctrl_b_reg[i][NEG_SEL_LSB +: 3] : NEG_GROUND; // [RULE17] [RULE15]
        end
      end

      // Pin path skips the cycle latch
      assign pin_result[i]  = selected[i]; // [RULE4]
      assign gate_source[i] = result_reg[i]; // [RULE7]
    end
  endgenerate

  assign result_next = result_reg;
  assign irq_request  = |(flag_reg & irq_en_reg);
  assign wake_request = |(flag_reg & irq_en_reg); // [RULE18]

  // Read mux; unmapped addresses and absent comparator read zero
  always_comb
  begin
    rdata_next = 8'h00;
    case (bus.addr)
      OFS_CTRL_A0:
        rdata_next = (ctrl_a_reg[0] & 8'h97) | ({7'h00, result_reg[0]} << BIT_RESULT); // [RULE2]
      OFS_CTRL_B0:
        rdata_next = ctrl_b_reg[0];
      OFS_CTRL_A1:
        if (NUM_CMP > 1)
          rdata_next = (ctrl_a_reg[NUM_CMP-1] & 8'h97)
                       | ({7'h00, result_next[NUM_CMP-1]} << BIT_RESULT);
      OFS_CTRL_B1:
        if (NUM_CMP > 1)
          rdata_next = ctrl_b_reg[NUM_CMP-1];
      OFS_MIRROR:
        rdata_next = 8'(result_reg); // [RULE2]
      OFS_IRQ_FLAG:
        rdata_next = 8'(flag_reg);
      OFS_IRQ_EN:
        rdata_next = 8'(irq_en_reg);
      default:
        rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (bus.rd)
      rdata <= rdata_next;
    else
      rdata <= 8'h00;
  end

endmodule // cmpd_top
`default_nettype wire

/* tb/cmpd_chk_asserts.sv */
// Concurrent checks on the comparator control block ports.
// Assumes binding into cmpd_top; watches comparator 0 controls only.
`timescale 1ns/1ns
`default_nettype none
module cmpd_chk
  import cmpd_pkg::*;
#(
  parameter int NUM_CMP = 2
)(
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire cmpd_bus_t                 bus,
  input wire logic [CMPD_DW-1:0]        rdata,
  input wire logic [NUM_CMP-1:0]        analog_raw,
  input wire logic                      timer_src_clk,
  input wire cmpd_analog_t [NUM_CMP-1:0] analog_ctrl,
  input wire logic [NUM_CMP-1:0]        gate_source,
  input wire logic                      irq_request,
  input wire logic                      wake_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == '0)
    else $error("read data not zero outside answer");
  a_result_read: assert property ($past(bus.rd) && $past(bus.addr) == OFS_CTRL_A0 |->
    rdata[BIT_RESULT] == $past(gate_source[0]) && !rdata[5] && !rdata[3])
    else $error("result bit read wrong");
  a_mirror_read: assert property ($past(bus.rd) && $past(bus.addr) == OFS_MIRROR |->
    rdata == {{(CMPD_DW-NUM_CMP){1'b0}}, $past(gate_source)})
    else $error("mirror read wrong");
  a_inputs_en: assert property (analog_ctrl[0].inputs_on == analog_ctrl[0].enable)
    else $error("inputs on while disabled");
  a_wake_irq: assert property (wake_request == irq_request)
    else $error("wake and interrupt differ");
  a_rise_cause: assert property ($rose(irq_request) |->
    $past(bus.wr) || $past(gate_source) != $past(gate_source, 2))
    else $error("interrupt without edge");
  a_fall_cause: assert property ($fell(irq_request) |-> $past(bus.wr))
    else $error("flag cleared without software");
  a_gate_steady: assert property (
    (!bus.wr && $stable(analog_raw) && $stable(timer_src_clk)) [*6] |-> $stable(gate_source))
    else $error("result moved with quiet inputs");
endmodule // cmpd_chk
bind cmpd_top cmpd_chk #(.NUM_CMP(NUM_CMP)) cmpd_chk_inst (.clk, .rstn, .bus, .rdata,
  .analog_raw, .timer_src_clk, .analog_ctrl, .gate_source, .irq_request, .wake_request);
`default_nettype wire

/* tb/cmpd_far.sv */
// Far side model: two analog comparators and the timer source clock.
// Assumes the bench sets input voltages; timer clock stands still unless run.
`timescale 1ns/1ns
`default_nettype none
module cmpd_far
  import cmpd_pkg::*;
(
  input  wire logic               clk,
  input  wire cmpd_analog_t [1:0] ctrl,
  input  wire logic [1:0][7:0]    vp,
  input  wire logic [1:0][7:0]    vn,
  input  wire logic               run,
  output logic [1:0]              raw,
  output logic                    tclk = 1'b0
);
  // Disconnected inputs give a low output, so no stale level leaks
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      raw[i] = ctrl[i].inputs_on && vp[i] > vn[i];
  end
  always @(posedge clk)
    if (run)
      tclk <= ~tclk;
endmodule // cmpd_far
`default_nettype wire

/* tb/comparator_digital_control_bench.sv */
// Register level bench for the comparator control block.
// Assumes cmpd_top with two comparators and the cmpd_far model.
`timescale 1ns/1ns
`default_nettype none
module comparator_digital_control_bench
  import cmpd_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  cmpd_bus_t bus = '0;
  logic [7:0] rdata;
  logic [1:0] analog_raw, gate_source, pin_result;
  logic timer_src_clk, irq_request, wake_request, run = 1'b0;
  logic timer_src_core = 1'b0, sleep_mode = 1'b0;
  logic [1:0][7:0] vp = '0, vn = '0;
  cmpd_analog_t [1:0] analog_ctrl;
  int fails = 0, n_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  cmpd_top #(.NUM_CMP(2)) cmpd_top_inst (.clk, .rstn, .bus, .rdata, .analog_raw,
    .timer_src_clk, .timer_src_core, .sleep_mode, .analog_ctrl, .gate_source,
    .pin_result, .irq_request, .wake_request);
  cmpd_far cmpd_far_inst (.clk, .ctrl(analog_ctrl), .vp, .vn, .run, .raw(analog_raw),
    .tclk(timer_src_clk));
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp, "rdata");
  endtask
  // Timeout far above the roughly 160 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_CTRL_A0, RST_CTRL_A);
    rd(OFS_CTRL_A1, RST_CTRL_A);
    rd(OFS_CTRL_B0, RST_CTRL_B);
    rd(OFS_IRQ_FLAG, RST_IRQ);
    rd(4'hF, 8'h00);
    vp[0] <= 8'h0A;
    vn[0] <= 8'h14;
    wr(OFS_CTRL_A0, 8'hC4);
    repeat (6) @(posedge clk);
    rd(OFS_CTRL_A0, 8'h84);
    wr(OFS_CTRL_B0, 8'hC0);
    wr(OFS_IRQ_EN, 8'h01);
    vp[0] <= 8'h1E;
    repeat (6) @(posedge clk);
    rd(OFS_CTRL_A0, 8'hC4);
    rd(OFS_MIRROR, 8'h01);
    rd(OFS_IRQ_FLAG, 8'h01);
    chk(irq_request, 1'b1, "irq_request");
    chk({pin_result[0], gate_source[0]}, 2'b11, "pin_gate");
    wr(OFS_IRQ_FLAG, 8'h00);
    rd(OFS_IRQ_FLAG, 8'h00);
    wr(OFS_CTRL_A0, 8'h04);
    repeat (6) @(posedge clk);
    rd(OFS_IRQ_FLAG, 8'h01);
    wr(OFS_IRQ_FLAG, 8'h00);
    wr(OFS_CTRL_A0, 8'h14);
    repeat (6) @(posedge clk);
    rd(OFS_IRQ_FLAG, 8'h01);
    rd(OFS_CTRL_A0, 8'h54);
    // Sync on: result waits for a timer clock fall
    wr(OFS_CTRL_A1, 8'h81);
    vp[1] <= 8'h09;
    repeat (8) @(posedge clk);
    rd(OFS_CTRL_A1, 8'h81);
    run <= 1'b1;
    repeat (10) @(posedge clk);
    rd(OFS_CTRL_A1, 8'hC1);
    chk(gate_source[1], 1'b1, "gate_source1");
    sleep_mode <= 1'b1;
    timer_src_core <= 1'b1;
    vp[1] <= 8'h00;
    repeat (10) @(posedge clk);
    rd(OFS_CTRL_A1, 8'hC1);
    sleep_mode <= 1'b0;
    repeat (10) @(posedge clk);
    rd(OFS_CTRL_A1, 8'h81);
    wr(OFS_MIRROR, 8'hFF);
    rd(OFS_MIRROR, 8'h01);
    wr(OFS_CTRL_A0, 8'h86);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_CTRL_B0, {2'b00, 3'(i), 3'(i % 3)});
      repeat (2) @(posedge clk);
      chk(analog_ctrl[0].pos_sel, 3'(i), "pos_sel");
      chk(analog_ctrl[0].neg_sel, 3'(i % 3), "neg_sel");
    end
    chk(analog_ctrl[0].hysteresis, 1'b1, "hysteresis");
    wr(OFS_CTRL_A0, 8'h00);
    repeat (2) @(posedge clk);
    chk(analog_ctrl[0].pos_sel, POS_GROUND, "pos_sel_off");
    chk(analog_ctrl[0].inputs_on, 1'b0, "inputs_on");
    wrap_up();
  end
endmodule // comparator_digital_control_bench
`default_nettype wire
